// *** verilog/switch_policy.sv ***
// apb register top of the unknown vlan forwarding and mac policy block
// Function
// R1: enable bit forwards unknown-vlan packets, reset clear
// R2: seven-bit port map, bit n is port n+1
// R3: alternate back-off only on half-duplex ports
// R4: software sets alternate back-off with no-collision-drop
// R5: length check discards mismatch when field below 1500
// R6: drop mode set drops type or pause address
// R7: drop mode clear drops only type and address
// R8: aggressive back-off for half-duplex back pressure, reset off
// R9: precedence vlan, then unicast, then multicast
// R10: new settings apply to packets after write
`timescale 1ns/1ns
`include "switch_policy_consts.svh"
module switch_policy (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           desc_valid,
  input  wire logic                           desc_vid_unknown,
  input  wire logic                           desc_uc_unknown,
  input  wire logic                           desc_mc_unknown,
  input  wire logic [15:0]                    desc_type_len,
  input  wire logic [47:0]                    desc_da,
  input  wire logic [15:0]                    desc_data_len,
  input  wire logic [6:0]                     port_half_duplex,
  output logic                                dec_valid,
  output switch_policy_pkg::fwd_class_t       dec_class,
  output logic                                dec_override,
  output logic      [6:0]                     dec_ports,
  output logic                                dec_drop,
  output logic      [6:0]                     alt_backoff,
  output logic      [6:0]                     aggr_backoff
);

  // ---------------- register state ----------------
  logic                           vlan_en_q;      // unknown vlan forward enable
  logic                           vlan_en_d;
  logic [6:0]                     vlan_ports_q;   // unknown vlan port map
  logic [6:0]                     vlan_ports_d;
  logic [7:0]                     mac0_q;         // mac control zero, all bits stored
  logic [7:0]                     mac0_d;

  // ---------------- bus answer state ----------------
  logic [31:0]                    prdata_q;       // read data captured in setup
  logic [31:0]                    prdata_d;
  logic                           pready_q;       // high in the first access cycle
  logic                           pready_d;
  logic                           pslverr_q;      // unmapped address answer
  logic                           pslverr_d;

  // ---------------- decision state ----------------
  logic                           dec_valid_q;    // one-cycle decision strobe
  logic                           dec_valid_d;
  switch_policy_pkg::fwd_class_t  dec_class_q;    // registered class
  switch_policy_pkg::fwd_class_t  dec_class_d;
  logic                           dec_override_q; // registered override flag
  logic                           dec_override_d;
  logic [6:0]                     dec_ports_q;    // registered port map
  logic [6:0]                     dec_ports_d;
  logic                           dec_drop_q;     // registered drop
  logic                           dec_drop_d;
  logic [6:0]                     alt_backoff_q;  // per-port alternate back-off
  logic [6:0]                     alt_backoff_d;
  logic [6:0]                     aggr_backoff_q; // per-port aggressive back-off
  logic [6:0]                     aggr_backoff_d;

  logic                           setup_cyc;      // apb setup phase
  logic                           wr_commit;      // write takes effect this edge

  classify_if                     cif ();         // link to classifier

  // address decode, used by the error path
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `UVID_CTRL_OFFSET) || (a == `MAC_CTRL0_OFFSET);
  endfunction

  // register read mux; reserved bits read as zero
  function automatic logic [31:0] read_word(input logic [11:0] a);
    read_word = 32'h00000000;
    if (a == `UVID_CTRL_OFFSET)
    begin
      read_word[`UVID_EN_BIT]                    = vlan_en_q;
      read_word[`UVID_PORTS_MSB:`UVID_PORTS_LSB] = vlan_ports_q;
    end
    else if (a == `MAC_CTRL0_OFFSET)
    begin
      read_word[7:0] = mac0_q;
    end
  endfunction

  // ---------------- apb slave ----------------
  // the answer is always ready in the first access cycle, so no wait states
  always_comb
  begin
    setup_cyc = psel && !penable;
    wr_commit = psel && penable && pready_q && pwrite;
    pready_d  = setup_cyc;
    pslverr_d = setup_cyc && !is_mapped(paddr);
    prdata_d  = prdata_q;
    if (setup_cyc && !pwrite)
    begin
      prdata_d = read_word(paddr);
    end
    else if (!psel)
    begin
      prdata_d = 32'h00000000;
    end
  end

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ---------------- register write ----------------
  // writes land only on the completing edge; unmapped writes are ignored
  always_comb
  begin
    vlan_en_d    = vlan_en_q;
    vlan_ports_d = vlan_ports_q;
    mac0_d       = mac0_q;
    if (wr_commit && (paddr == `UVID_CTRL_OFFSET))
    begin
      // R1: enable bit write
      vlan_en_d    = pwdata[`UVID_EN_BIT];
      // R2: port map write
      vlan_ports_d = pwdata[`UVID_PORTS_MSB:`UVID_PORTS_LSB];
    end
    else if (wr_commit && (paddr == `MAC_CTRL0_OFFSET))
    begin
      mac0_d = pwdata[7:0];
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vlan_en_q    <= `UVID_EN_RESET;
      vlan_ports_q <= `UVID_PORTS_RESET;
      mac0_q       <= `MAC0_RESET;
    end
    else
    begin
      vlan_en_q    <= vlan_en_d;
      vlan_ports_q <= vlan_ports_d;
      mac0_q       <= mac0_d;
    end
  end

  // ---------------- classifier link ----------------
  // R10: descriptor sees committed settings
  assign cif.vlan_en     = vlan_en_q;
  assign cif.vlan_ports  = vlan_ports_q;
  assign cif.len_check   = mac0_q[`MAC0_LEN_CHECK_BIT];
  assign cif.fc_drop_any = mac0_q[`MAC0_FC_DROP_BIT];
  assign cif.vid_unknown = desc_vid_unknown;
  assign cif.uc_unknown  = desc_uc_unknown;
  assign cif.mc_unknown  = desc_mc_unknown;
  assign cif.type_len    = desc_type_len;
  assign cif.da          = desc_da;
  assign cif.data_len    = desc_data_len;

  frame_classifier u_cls (
    .c (cif)
  );

  // ---------------- decision and back-off ----------------
  // a decision is taken once per descriptor, so a setting that changes later
  // cannot reach a packet already decided
  always_comb
  begin
    dec_valid_d    = desc_valid;
    dec_class_d    = dec_class_q;
    dec_override_d = dec_override_q;
    dec_ports_d    = dec_ports_q;
    dec_drop_d     = dec_drop_q;
    if (desc_valid)
    begin
      dec_class_d    = cif.cls;
      dec_override_d = cif.override;
      dec_ports_d    = cif.ports;
      dec_drop_d     = cif.drop;
    end
    // R3: alternate back-off, half-duplex only
    alt_backoff_d  = mac0_q[`MAC0_ALT_BACKOFF_BIT] ? port_half_duplex : 7'h00;
    // R8: aggressive back-off, half-duplex only
    aggr_backoff_d = mac0_q[`MAC0_AGGR_BIT] ? port_half_duplex : 7'h00;
  end

  // decision registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_valid_q    <= 1'b0;
      dec_class_q    <= switch_policy_pkg::CLS_NONE;
      dec_override_q <= 1'b0;
      dec_ports_q    <= 7'h00;
      dec_drop_q     <= 1'b0;
      alt_backoff_q  <= 7'h00;
      aggr_backoff_q <= 7'h00;
    end
    else
    begin
      dec_valid_q    <= dec_valid_d;
      dec_class_q    <= dec_class_d;
      dec_override_q <= dec_override_d;
      dec_ports_q    <= dec_ports_d;
      dec_drop_q     <= dec_drop_d;
      alt_backoff_q  <= alt_backoff_d;
      aggr_backoff_q <= aggr_backoff_d;
    end
  end

  // outputs straight from flops
  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign dec_valid    = dec_valid_q;
  assign dec_class    = dec_class_q;
  assign dec_override = dec_override_q;
  assign dec_ports    = dec_ports_q;
  assign dec_drop     = dec_drop_q;
  assign alt_backoff  = alt_backoff_q;
  assign aggr_backoff = aggr_backoff_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // R1: enabled unknown vlan overrides
  property p_vlan_fwd;
    desc_valid && desc_vid_unknown && vlan_en_q |=> dec_override_q && dec_valid_q;
  endproperty
  a_vlan_fwd: assert property (p_vlan_fwd) else $error("unknown vlan not forwarded"); // R1

  // R1: disabled means no override
  property p_vlan_off;
    desc_valid && !vlan_en_q |=> !dec_override_q && (dec_ports_q == 7'h00);
  endproperty
  a_vlan_off: assert property (p_vlan_off) else $error("override while disabled"); // R1

  // R2: port map, old value if written at once
  property p_vlan_ports;
    desc_valid && desc_vid_unknown && vlan_en_q |=> dec_ports_q == $past(vlan_ports_q);
  endproperty
  a_vlan_ports: assert property (p_vlan_ports) else $error("wrong unknown vlan ports"); // R2

  // R3: full-duplex ports never alternate
  property p_alt_full;
    ##1 (alt_backoff_q & ~$past(port_half_duplex)) == 7'h00;
  endproperty
  a_alt_full: assert property (p_alt_full) else $error("alternate back-off on full duplex"); // R3

  // R5: mismatched short length dropped
  property p_len_drop;
    desc_valid && mac0_q[`MAC0_LEN_CHECK_BIT] && (desc_type_len < `LEN_FIELD_LIMIT)
      && (desc_type_len != desc_data_len) |=> dec_drop_q;
  endproperty
  a_len_drop: assert property (p_len_drop) else $error("length mismatch kept"); // R5

  // R6: either pause match dropped
  property p_fc_any;
    desc_valid && mac0_q[`MAC0_FC_DROP_BIT]
      && ((desc_type_len == `FC_ETHERTYPE) || (desc_da == `PAUSE_DA)) |=> dec_drop_q;
  endproperty
  a_fc_any: assert property (p_fc_any) else $error("flow control packet kept"); // R6

  // R7: type alone not dropped in strict mode
  property p_fc_both;
    desc_valid && !mac0_q[`MAC0_FC_DROP_BIT] && (desc_type_len == `FC_ETHERTYPE)
      && (desc_da != `PAUSE_DA) |=> !dec_drop_q;
  endproperty
  a_fc_both: assert property (p_fc_both) else $error("type only packet dropped"); // R7

  // R8: aggressive back-off follows bit on half duplex
  property p_aggr;
    mac0_q[`MAC0_AGGR_BIT] && (port_half_duplex != 7'h00) ##1 mac0_q[`MAC0_AGGR_BIT]
      |-> aggr_backoff_q == $past(port_half_duplex);
  endproperty
  a_aggr: assert property (p_aggr) else $error("aggressive back-off wrong"); // R8

  // R9: vlan precedence over unicast
  property p_prec;
    desc_valid && desc_vid_unknown && (desc_uc_unknown || desc_mc_unknown)
      |=> dec_class_q == switch_policy_pkg::CLS_VLAN;
  endproperty
  a_prec: assert property (p_prec) else $error("precedence broken"); // R9

  // R10: a write does not touch the override decision of the same edge
  property p_late_write;
    desc_valid && wr_commit && (paddr == `UVID_CTRL_OFFSET)
      |=> dec_override_q == ($past(vlan_en_q) && $past(desc_vid_unknown));
  endproperty
  a_late_write: assert property (p_late_write) else $error("write leaked into decision"); // R10

endmodule

// *** verilog/switch_policy_consts.svh ***
// offsets, field positions, reset values and frame constants of the switch policy block
`ifndef SWITCH_POLICY_CONSTS_SVH
`define SWITCH_POLICY_CONSTS_SVH

// register byte addresses
`define UVID_CTRL_OFFSET     12'h328
`define MAC_CTRL0_OFFSET     12'h330

// unknown vlan forward control fields
`define UVID_EN_BIT          31
`define UVID_PORTS_MSB       6
`define UVID_PORTS_LSB       0
`define UVID_PORTS_RESET     7'h00
`define UVID_EN_RESET        1'h0

// mac control zero fields
`define MAC0_ALT_BACKOFF_BIT 7
`define MAC0_LEN_CHECK_BIT   3
`define MAC0_FC_DROP_BIT     1
`define MAC0_AGGR_BIT        0
`define MAC0_RESET           8'h04

// frame constants
`define FC_ETHERTYPE         16'h8808
`define PAUSE_DA             48'h0180c2000001
`define LEN_FIELD_LIMIT      16'h05dc

`endif

// *** verilog/switch_policy_pkg.sv ***
// types shared by the switch policy block
package switch_policy_pkg;

  // forwarding class of a received packet, CLS_NONE first, then vlan, unicast, multicast in precedence order
  typedef enum logic [1:0] {
    CLS_NONE,
    CLS_VLAN,
    CLS_UCAST,
    CLS_MCAST
  } fwd_class_t;

endpackage

// *** verilog/classify_if.sv ***
// carries settings, packet descriptor and decision between register top and classifier
`timescale 1ns/1ns
interface classify_if;
  logic                           vlan_en;      // unknown vlan forwarding enabled
  logic [6:0]                     vlan_ports;   // unknown vlan target ports
  logic                           len_check;    // length field check enabled
  logic                           fc_drop_any;  // drop on either pause match
  logic                           vid_unknown;  // packet vlan id unknown
  logic                           uc_unknown;   // packet unicast da unknown
  logic                           mc_unknown;   // packet multicast da unknown
  logic [15:0]                    type_len;     // ethertype or length field
  logic [47:0]                    da;           // destination address
  logic [15:0]                    data_len;     // actual data field length
  switch_policy_pkg::fwd_class_t  cls;          // resulting class
  logic                           override;     // port map override applies
  logic [6:0]                     ports;        // override port map
  logic                           drop;         // packet is to be dropped

  modport top (output vlan_en, vlan_ports, len_check, fc_drop_any, vid_unknown, uc_unknown,
               mc_unknown, type_len, da, data_len, input cls, override, ports, drop);
  modport cls_end (input vlan_en, vlan_ports, len_check, fc_drop_any, vid_unknown, uc_unknown,
                   mc_unknown, type_len, da, data_len, output cls, override, ports, drop);
endinterface

// *** verilog/frame_classifier.sv ***
// combinational packet classification and drop decision
`timescale 1ns/1ns
`include "switch_policy_consts.svh"
module frame_classifier (
  classify_if.cls_end  c
);

  logic  short_field;  // type/length is a length, not a type
  logic  len_bad;      // length field disagrees with real length
  logic  is_fc_type;   // mac control ethertype
  logic  is_pause_da;  // pause multicast destination

  // frame field matches
  always_comb
  begin
    // R5: only below limit
    short_field = c.type_len < `LEN_FIELD_LIMIT;
    len_bad     = short_field && (c.type_len != c.data_len);
    is_fc_type  = c.type_len == `FC_ETHERTYPE;
    is_pause_da = c.da == `PAUSE_DA;
  end

  // class, port override and drop
  always_comb
  begin
    c.cls      = switch_policy_pkg::CLS_NONE;
    c.override = 1'b0;
    c.ports    = 7'h00;
    c.drop     = 1'b0;
    // R9: vlan before unicast before multicast
    if (c.vid_unknown)
    begin
      c.cls = switch_policy_pkg::CLS_VLAN;
      // R1: override only when enabled
      if (c.vlan_en)
      begin
        c.override = 1'b1;
        // R2: one bit per port
        c.ports = c.vlan_ports;
      end
    end
    else if (c.uc_unknown)
    begin
      c.cls = switch_policy_pkg::CLS_UCAST;
    end
    else if (c.mc_unknown)
    begin
      c.cls = switch_policy_pkg::CLS_MCAST;
    end
    // R6: drop on either match
    if (c.fc_drop_any)
    begin
      if (is_fc_type || is_pause_da)
      begin
        c.drop = 1'b1;
      end
    end
    // R7: drop only on both
    else if (is_fc_type && is_pause_da)
    begin
      c.drop = 1'b1;
    end
    // R5: length mismatch discard
    if (c.len_check && len_bad)
    begin
      c.drop = 1'b1;
    end
  end

endmodule

// *** tb/link_partner_model.sv ***
// link partner model offering received packet descriptors and port duplex state
`timescale 1ns/1ns
module link_partner_model (
  input  wire logic        pclk,
  output logic             desc_valid,
  output logic             desc_vid_unknown,
  output logic             desc_uc_unknown,
  output logic             desc_mc_unknown,
  output logic [15:0]      desc_type_len,
  output logic [47:0]      desc_da,
  output logic [15:0]      desc_data_len,
  output logic [6:0]       port_half_duplex
);
  // quiet link, all ports full duplex
  initial
  begin
    desc_valid = 1'b0;
    {desc_vid_unknown, desc_uc_unknown, desc_mc_unknown} = 3'h0;
    desc_type_len = 16'h0000;
    desc_da = 48'h000000000000;
    desc_data_len = 16'h0000;
    port_half_duplex = 7'h00;
  end

  // one descriptor for one clock; fields are scrambled after so stale values never look valid
  task automatic send(input logic [2:0] cat, input logic [15:0] tl, input logic [47:0] da,
                      input logic [15:0] len);
    @(posedge pclk);
    desc_valid <= 1'b1;
    {desc_vid_unknown, desc_uc_unknown, desc_mc_unknown} <= cat;
    desc_type_len <= tl;
    desc_da <= da;
    desc_data_len <= len;
    @(posedge pclk);
    desc_valid <= 1'b0;
    {desc_vid_unknown, desc_uc_unknown, desc_mc_unknown} <= ~cat;
    desc_type_len <= ~tl;
    desc_da <= ~da;
    desc_data_len <= ~len;
  endtask

  // duplex changes as a link renegotiates
  task automatic set_duplex(input logic [6:0] hd);
    @(posedge pclk);
    port_half_duplex <= hd;
  endtask
endmodule

// *** tb/switch_policy_tb.sv ***
// self-checking bench for the unknown vlan forwarding and mac policy block
`timescale 1ns/1ns
`include "switch_policy_consts.svh"
module switch_policy_tb;
  logic        pclk;           // apb and switch clock
  logic        presetn;        // async reset, active low
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        dv;             // descriptor valid
  logic [2:0]  cat;            // vid, unicast, multicast unknown
  logic [15:0] tl;
  logic [47:0] da;
  logic [15:0] len;
  logic [6:0]  hd;             // half duplex per port
  logic        dec_valid;
  switch_policy_pkg::fwd_class_t dec_class;
  logic        dec_override;
  logic [6:0]  dec_ports;
  logic        dec_drop;
  logic [6:0]  alt_backoff;
  logic [6:0]  aggr_backoff;
  int          bad_count;
  int          n_compared;
  localparam logic [47:0] PLAIN_DA = 48'h020000000001;  // ordinary unicast address

  link_partner_model u_link (.pclk(pclk), .desc_valid(dv), .desc_vid_unknown(cat[2]),
    .desc_uc_unknown(cat[1]), .desc_mc_unknown(cat[0]), .desc_type_len(tl), .desc_da(da),
    .desc_data_len(len), .port_half_duplex(hd));

  switch_policy dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .desc_valid(dv), .desc_vid_unknown(cat[2]), .desc_uc_unknown(cat[1]),
    .desc_mc_unknown(cat[0]), .desc_type_len(tl), .desc_da(da), .desc_data_len(len),
    .port_half_duplex(hd), .dec_valid(dec_valid), .dec_class(dec_class),
    .dec_override(dec_override), .dec_ports(dec_ports), .dec_drop(dec_drop),
    .alt_backoff(alt_backoff), .aggr_backoff(aggr_backoff));

  // clock generator
  always #50 pclk = ~pclk;

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // apb transfer; holds the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count is assumed; a slave that never answers is caught by the watchdog
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    check(r, exp);
    check(e, exp_err);
  endtask

  // one packet through the classifier, decision sampled one edge after it is taken
  task automatic pkt(input logic [2:0] c, input logic [15:0] t, input logic [47:0] d,
                     input logic [15:0] l, input switch_policy_pkg::fwd_class_t ecls,
                     input logic eovr, input logic [6:0] eports, input logic edrop);
    u_link.send(c, t, d, l);
    @(posedge pclk);
    check(dec_valid, 1'b1);
    check(dec_class, ecls);
    check(dec_override, eovr);
    check(dec_ports, eports);
    check(dec_drop, edrop);
  endtask

  task automatic t_reset_and_regs;
    rd_chk(`UVID_CTRL_OFFSET, 32'h00000000, 1'b0);
    rd_chk(`MAC_CTRL0_OFFSET, 32'h00000004, 1'b0);
    rd_chk(12'h32c, 32'h00000000, 1'b1);
    wr(`UVID_CTRL_OFFSET, 32'hffffffff);
    rd_chk(`UVID_CTRL_OFFSET, 32'h8000007f, 1'b0);
    wr(`MAC_CTRL0_OFFSET, 32'hffffffff);
    rd_chk(`MAC_CTRL0_OFFSET, 32'h000000ff, 1'b0);
    // unmapped write must leave the mac control zero register alone
    wr(12'h334, 32'h00000000);
    rd_chk(`MAC_CTRL0_OFFSET, 32'h000000ff, 1'b0);
    wr(`MAC_CTRL0_OFFSET, 32'h00000004);
  endtask

  task automatic t_vlan;
    switch_policy_pkg::fwd_class_t ec;
    wr(`UVID_CTRL_OFFSET, 32'h80000055);
    // every mix of the three unknown categories
    for (int i = 0; i < 8; i++)
    begin
      ec = i[2] ? switch_policy_pkg::CLS_VLAN : i[1] ? switch_policy_pkg::CLS_UCAST :
           i[0] ? switch_policy_pkg::CLS_MCAST : switch_policy_pkg::CLS_NONE;
      pkt(i[2:0], 16'h0800, PLAIN_DA, 16'h0000, ec, i[2], i[2] ? 7'h55 : 7'h00, 1'b0);
    end
    wr(`UVID_CTRL_OFFSET, 32'h0000007f);
    pkt(3'h4, 16'h0800, PLAIN_DA, 16'h0000, switch_policy_pkg::CLS_VLAN, 1'b0, 7'h00, 1'b0);
    wr(`UVID_CTRL_OFFSET, 32'h8000007f);
    pkt(3'h6, 16'h0800, PLAIN_DA, 16'h0000, switch_policy_pkg::CLS_VLAN, 1'b1, 7'h7f, 1'b0);
    wr(`UVID_CTRL_OFFSET, 32'h80000000);
    pkt(3'h4, 16'h0800, PLAIN_DA, 16'h0000, switch_policy_pkg::CLS_VLAN, 1'b1, 7'h00, 1'b0);
    // descriptor taken on the very edge the write commits must still see the old settings
    fork
      wr(`UVID_CTRL_OFFSET, 32'h00000033);
      begin
        @(posedge pclk);
        u_link.send(3'h4, 16'h0800, PLAIN_DA, 16'h0000);
      end
    join
    @(posedge pclk);
    check(dec_valid, 1'b1);
    check(dec_override, 1'b1);
    check(dec_ports, 7'h00);
    // the next descriptor picks up the new, disabled setting
    pkt(3'h4, 16'h0800, PLAIN_DA, 16'h0000, switch_policy_pkg::CLS_VLAN, 1'b0, 7'h00, 1'b0);
  endtask

  task automatic t_flow_control;
    logic tm;
    logic dm;
    for (int m = 0; m < 2; m++)
    begin
      wr(`MAC_CTRL0_OFFSET, m[0] ? 32'h00000006 : 32'h00000004);
      for (int j = 0; j < 4; j++)
      begin
        tm = j[1];
        dm = j[0];
        pkt(3'h0, tm ? `FC_ETHERTYPE : 16'h0800, dm ? `PAUSE_DA : PLAIN_DA, 16'h0000,
            switch_policy_pkg::CLS_NONE, 1'b0, 7'h00, m[0] ? (tm | dm) : (tm & dm));
      end
    end
  endtask

  task automatic t_length;
    wr(`MAC_CTRL0_OFFSET, 32'h0000000c);
    pkt(3'h0, 16'h0040, PLAIN_DA, 16'h0041, switch_policy_pkg::CLS_NONE, 1'b0, 7'h00, 1'b1);
    pkt(3'h0, 16'h0040, PLAIN_DA, 16'h0040, switch_policy_pkg::CLS_NONE, 1'b0, 7'h00, 1'b0);
    pkt(3'h0, 16'h05db, PLAIN_DA, 16'h0000, switch_policy_pkg::CLS_NONE, 1'b0, 7'h00, 1'b1);
    pkt(3'h0, 16'h05dc, PLAIN_DA, 16'h0000, switch_policy_pkg::CLS_NONE, 1'b0, 7'h00, 1'b0);
    wr(`MAC_CTRL0_OFFSET, 32'h00000004);
    pkt(3'h0, 16'h0040, PLAIN_DA, 16'h0041, switch_policy_pkg::CLS_NONE, 1'b0, 7'h00, 1'b0);
  endtask

  task automatic t_backoff;
    u_link.set_duplex(7'h2d);
    // software pairs alternate back-off with the keep-after-collisions setting
    // software recommendation
    wr(`MAC_CTRL0_OFFSET, 32'h00000085);
    repeat (3) @(posedge pclk);
    check(alt_backoff, 7'h2d);
    check(aggr_backoff, 7'h2d);
    wr(`MAC_CTRL0_OFFSET, 32'h00000080);
    u_link.set_duplex(7'h52);
    repeat (3) @(posedge pclk);
    check(alt_backoff, 7'h52);
    check(aggr_backoff, 7'h00);
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    bad_count = 0;
    n_compared = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_and_regs();
    t_vlan();
    t_flow_control();
    t_length();
    t_backoff();
    final_report();
  end

  // watchdog, far beyond the roughly 160 cycles the scenarios need
  initial
  begin
    #(5000 * 100);
    bad_count++;
    final_report();
  end
endmodule
